// file: hdl/flp_pkg.sv
// flp_pkg: constants shared by the framer line and highway pin block
// assumes a 50 MHz core clock and a 32-bit AHB-Lite register port
package flp_pkg;
	localparam int          CORE_HZ        = 50_000_000;
	localparam int          TX_DS1_HZ      = 1_544_000;
	localparam int          TX_CEPT_HZ     = 2_048_000;
	localparam int          NCO_W          = 24;
	// step gives two toggles per line clock period
	localparam logic [23:0] NCO_STEP_DS1   = 24'((64'(2 * TX_DS1_HZ) << NCO_W) / 64'(CORE_HZ));
	localparam logic [23:0] NCO_STEP_CEPT  = 24'((64'(2 * TX_CEPT_HZ) << NCO_W) / 64'(CORE_HZ));

	localparam logic [7:0]  DS1_LAST_BIT   = 8'hC0;
	localparam logic [7:0]  CEPT_LAST_BIT  = 8'hFF;
	localparam logic [7:0]  ALIGN_END_BIT  = 8'h07;
	localparam logic [7:0]  DDS_HALF_BIT   = 8'h60;
	localparam logic [6:0]  CEPT_FAS_PAT   = 7'h1B;
	localparam logic [6:0]  DS1_HUNT_PAT   = 7'h4D;
	localparam logic [1:0]  LOSS_ERR_LIMIT = 2'h3;
	localparam logic [7:0]  SA_BASE_BIT    = 8'h03;
	localparam logic [2:0]  SA_MAX_SEL     = 3'h4;
	localparam logic [11:0] HW_BASE_PERIOD = 12'h100;
	localparam logic [4:0]  SYSCLK_MULT_HI = 5'h10;
	localparam logic [4:0]  SYSCLK_MULT_LO = 5'h01;

	localparam logic [31:0] CTRL_OFF       = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFF     = 32'h0000_0004;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK      = 32'h0000_037F;
	localparam int          CTRL_SINGLE    = 0;
	localparam int          CTRL_CEPT      = 1;
	localparam int          CTRL_DDS       = 2;
	localparam int          CTRL_MASTER    = 3;
	localparam int          CTRL_SA_LSB    = 4;
	localparam int          CTRL_HWR_LSB   = 8;
	localparam int          STAT_LOSS      = 0;
	localparam int          STAT_LIU       = 1;
	localparam int          STAT_SEL16     = 2;
	localparam int          STAT_HWFS      = 3;
	localparam int          STAT_BPV_LSB   = 16;
endpackage : flp_pkg

// file: hdl/flp_sync.sv
// flp_sync: two-stage synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no bus coherence is promised
`timescale 1ns/1ps
module flp_sync #(
	parameter int W = 1
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_sys_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} flp_sync_st_t;

	flp_sync_st_t st;
	flp_sync_st_t next_st;

	// first stage is read by the second stage only
	always_comb begin
		next_st      = st;
		next_st.meta = i_async;
		next_st.sync = st.meta;
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_sync = st.sync;
endmodule : flp_sync

// file: hdl/flp_nco.sv
// flp_nco: phase accumulator giving a fractional-rate tick
// assumes the step is below half the accumulator range
`timescale 1ns/1ps
module flp_nco
	import flp_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_sys_rst,
	input  wire logic [NCO_W-1:0]  i_step,
	output logic                   o_tick
);
	typedef struct packed {
		logic [NCO_W-1:0] acc;
		logic             tick;
	} flp_nco_st_t;

	flp_nco_st_t      st;
	flp_nco_st_t      next_st;
	logic [NCO_W:0]   sum;

	// average rate is exact; each edge jitters by one core cycle
	always_comb begin
		next_st      = st;
		sum          = {1'b0, st.acc} + {1'b0, i_step};
		next_st.acc  = sum[NCO_W-1:0];
		next_st.tick = sum[NCO_W];
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_tick = st.tick;
endmodule : flp_nco

// file: hdl/flp_top.sv
// flp_top: one channel's framer line pins, receive framer outputs and highway sync
// assumes an AHB-Lite master on i_core_clk; line and highway pins are asynchronous
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module flp_top
	import flp_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_tx_pos_data,
	input  wire logic        i_tx_neg_data,
	output logic             o_tx_data_take,
	output logic             o_tx_pos_rail_out,
	output logic             o_tx_neg_rail_out,
	output logic             o_tx_line_clk_out,
	input  wire logic        i_rx_line_clk_in,
	input  wire logic        i_rx_pos_rail_in,
	input  wire logic        i_rx_neg_rail_in,
	input  wire logic        i_line_bypass_strap,
	input  wire logic        i_sysclk_rate_select,
	output logic      [4:0]  o_line_unit_sysclk_mult,
	output logic             o_rx_framer_clk_out,
	output logic             o_rx_decoded_data_out,
	output logic             o_rx_frame_sync_out,
	output logic             o_rx_sig_multiframe_sync,
	output logic             o_rx_crc_multiframe_sync,
	output logic             o_rx_datalink_clk,
	output logic             o_rx_datalink_out,
	output logic             o_rx_align_lost,
	input  wire logic        i_tx_highway_clk,
	input  wire logic        i_tx_highway_frame_sync_in,
	output logic             o_tx_highway_frame_sync_out,
	output logic             o_tx_highway_frame_sync_oe
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] hrdata;
		logic        wr_ctrl;
		logic        tx_line_clk_out;
		logic        tpos;
		logic        tneg;
		logic        take;
		logic [6:0]  per;
		logic        fresh;
		logic        rclk_d;
		logic        rxclk;
		logic [7:0]  bit_cnt;
		logic [3:0]  frm;
		logic [6:0]  hist;
		logic        loss;
		logic [1:0]  err;
		logic        rdata;
		logic        fs;
		logic        smf;
		logic        cmf;
		logic        dlclk;
		logic        dl;
		logic        dlbit;
		logic [15:0] bpv;
		logic        hclk_d;
		logic [11:0] hcnt;
		logic        hfs;
		logic [4:0]  mult;
	} flp_top_st_t;

	flp_top_st_t  st;
	flp_top_st_t  next_st;
	logic [6:0]   s_pins;
	logic         s_rclk;
	logic         s_rpos;
	logic         s_rneg;
	logic         s_liu;
	logic         s_sel16;
	logic         s_hclk;
	logic         s_hfs;
	logic         tick;
	logic         single;
	logic         cept;
	logic         dds8;
	logic         master;
	logic         rx_rise;
	logic         hw_rise;
	logic         rbit;
	logic [6:0]   win;
	logic [6:0]   pat;
	logic [7:0]   last_bit;
	logic [7:0]   sa_bit;
	logic [2:0]   sa_sel;
	logic [11:0]  hw_last;
	logic         take_dl;
	logic [31:0]  rd_val;
	logic         addr_ok;

	// every pin from outside the core domain passes two flops
	flp_sync #(.W(7)) u_sync (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_async    ({i_rx_line_clk_in, i_rx_pos_rail_in, i_rx_neg_rail_in,
		              i_line_bypass_strap, i_sysclk_rate_select,
		              i_tx_highway_clk, i_tx_highway_frame_sync_in}),
		.o_sync     (s_pins)
	);
	assign {s_rclk, s_rpos, s_rneg, s_liu, s_sel16, s_hclk, s_hfs} = s_pins;

	flp_nco u_nco (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_step     (cept ? NCO_STEP_CEPT : NCO_STEP_DS1),
		.o_tick     (tick)
	);

	assign single  = st.ctrl[CTRL_SINGLE];
	assign cept    = st.ctrl[CTRL_CEPT];
	assign dds8    = !cept && st.ctrl[CTRL_DDS];
	assign master  = st.ctrl[CTRL_MASTER];
	assign rx_rise = s_rclk && !st.rclk_d;
	assign hw_rise = s_hclk && !st.hclk_d;
	assign sa_sel  = (st.ctrl[CTRL_SA_LSB +: 3] > SA_MAX_SEL) ? SA_MAX_SEL
	                 : st.ctrl[CTRL_SA_LSB +: 3];
	assign sa_bit  = SA_BASE_BIT + {5'h00, sa_sel};
	assign hw_last = (HW_BASE_PERIOD << st.ctrl[CTRL_HWR_LSB +: 2]) - 12'h001;

	always_comb begin
		next_st      = st;
		next_st.take = 1'b0;
		rbit         = single ? s_rpos : (s_rpos | s_rneg);
		win          = {st.hist[5:0], rbit};
		pat          = cept ? CEPT_FAS_PAT : DS1_HUNT_PAT;
		last_bit     = cept ? CEPT_LAST_BIT : DS1_LAST_BIT;
		take_dl      = 1'b0;
		addr_ok      = 1'b0;
		rd_val       = 32'h0000_0000;

		// register port: zero wait states, always OKAY
		if (st.wr_ctrl) begin
			next_st.ctrl  = i_hwdata & CTRL_MASK;
			next_st.fresh = 1'b1;
		end
		next_st.wr_ctrl = 1'b0;
		if (i_hsel && i_hready && i_htrans[1]) begin
			if (i_haddr == CTRL_OFF) begin
				addr_ok = 1'b1;
				rd_val  = next_st.ctrl;
			end else if (i_haddr == STATUS_OFF) begin
				addr_ok                    = 1'b1;
				rd_val[STAT_LOSS]          = st.loss;
				rd_val[STAT_LIU]           = s_liu;
				rd_val[STAT_SEL16]         = s_sel16;
				rd_val[STAT_HWFS]          = s_hfs;
				rd_val[STAT_BPV_LSB +: 16] = st.bpv;
			end
			next_st.wr_ctrl = i_hwrite && (i_hsize == 3'h2) && (i_haddr == CTRL_OFF);
			if (!i_hwrite) begin
				next_st.hrdata = addr_ok ? rd_val : 32'h0000_0000;
			end
		end

		// transmit side
		next_st.per = (st.per == 7'h7F) ? st.per : st.per + 7'h01;
		if (tick) begin
			next_st.tx_line_clk_out = !st.tx_line_clk_out;
			if (!st.tx_line_clk_out) begin
				next_st.take  = 1'b1;
				next_st.per   = 7'h01;
				next_st.fresh = st.wr_ctrl;
				next_st.tpos  = s_liu ? 1'b0 : i_tx_pos_data;
				next_st.tneg  = s_liu ? 1'b0 : i_tx_neg_data;
			end
		end
		if (next_st.ctrl[CTRL_SINGLE]) begin
			next_st.tneg = 1'b0;
		end

		// receive side: sampled on the recovered clock's rising edge
		next_st.rclk_d = s_rclk;
		next_st.rxclk  = s_liu ? 1'b0 : s_rclk;
		if (rx_rise && !s_liu) begin
			next_st.hist = win;
			if (st.bit_cnt == last_bit) begin
				next_st.bit_cnt = 8'h00;
				next_st.frm     = st.frm + 4'h1;
			end else begin
				next_st.bit_cnt = st.bit_cnt + 8'h01;
			end
			if (st.loss) begin
				if (win == pat) begin
					next_st.loss    = 1'b0;
					next_st.err     = 2'h0;
					next_st.bit_cnt = ALIGN_END_BIT + 8'h01;
					next_st.frm     = 4'h0;
				end
			end else if (st.bit_cnt == ALIGN_END_BIT && (!cept || !st.frm[0])) begin
				// three bad words in a row before declaring loss
				if (win == pat) begin
					next_st.err = 2'h0;
				end else if (st.err == LOSS_ERR_LIMIT - 2'h1) begin
					next_st.loss = 1'b1;
					next_st.err  = 2'h0;
				end else begin
					next_st.err = st.err + 2'h1;
				end
			end
			next_st.rdata = next_st.loss ? 1'b1 : rbit;
			next_st.fs    = (st.bit_cnt == 8'h00);
			next_st.smf   = cept && (st.bit_cnt == 8'h00) && (st.frm == 4'h0);
			next_st.cmf   = cept && (st.bit_cnt == 8'h00) && (st.frm == 4'h0);
			if (cept) begin
				take_dl = (st.bit_cnt == sa_bit) && st.frm[0];
			end else begin
				take_dl = (st.bit_cnt == 8'h00) && (dds8 || st.frm[0]);
			end
			if (take_dl) begin
				next_st.dlbit = rbit;
			end
			next_st.dlclk = dds8 ? (next_st.bit_cnt >= DDS_HALF_BIT) : next_st.frm[0];
			if (st.dlclk && !next_st.dlclk) begin
				next_st.dl = next_st.dlbit;
			end
			if (single && s_rneg && st.bpv != 16'hFFFF) begin
				next_st.bpv = st.bpv + 16'h0001;
			end
		end
		if (next_st.loss) begin
			next_st.dl = 1'b1;
		end

		// highway frame sync: slave holds the output low, master counts highway clocks
		next_st.hclk_d = s_hclk;
		if (!master) begin
			next_st.hfs  = 1'b0;
			next_st.hcnt = 12'h000;
		end else if (hw_rise) begin
			next_st.hfs  = (st.hcnt == 12'h000);
			next_st.hcnt = (st.hcnt >= hw_last) ? 12'h000 : st.hcnt + 12'h001;
		end

		next_st.mult = s_sel16 ? SYSCLK_MULT_HI : SYSCLK_MULT_LO;
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st       <= '0;
			st.ctrl  <= CTRL_RST;
			st.loss  <= 1'b1;
			st.rdata <= 1'b1;
			st.dl    <= 1'b1;
			st.fresh <= 1'b1;
			st.mult  <= SYSCLK_MULT_LO;
		end else begin
			st <= next_st;
		end
	end

	assign o_hrdata                    = st.hrdata;
	assign o_hreadyout                 = 1'b1;
	assign o_hresp                     = 1'b0;
	assign o_tx_data_take              = st.take;
	assign o_tx_pos_rail_out           = st.tpos;
	assign o_tx_neg_rail_out           = st.tneg;
	assign o_tx_line_clk_out           = st.tx_line_clk_out;
	assign o_line_unit_sysclk_mult     = st.mult;
	assign o_rx_framer_clk_out         = st.rxclk;
	assign o_rx_decoded_data_out       = st.rdata;
	assign o_rx_frame_sync_out         = st.fs;
	assign o_rx_sig_multiframe_sync    = st.smf;
	assign o_rx_crc_multiframe_sync    = st.cmf;
	assign o_rx_datalink_clk           = st.dlclk;
	assign o_rx_datalink_out           = st.dl;
	assign o_rx_align_lost             = st.loss;
	assign o_tx_highway_frame_sync_out = st.hfs;
	assign o_tx_highway_frame_sync_oe  = master;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	localparam int DS1_PER_MIN  = 32;
	localparam int DS1_PER_MAX  = 33;
	localparam int CEPT_PER_MIN = 24;
	localparam int CEPT_PER_MAX = 25;

	a_neg_rail_zero: assert property (
		single |-> !o_tx_neg_rail_out)
		else $error("negative rail not zero in single rail");
	a_rail_on_rise: assert property (
		$changed(o_tx_pos_rail_out) |-> ($rose(o_tx_line_clk_out) && o_tx_data_take))
		else $error("positive rail changed off the line clock rise");
	a_tx_line_clk_out_period: assert property (
		($rose(o_tx_line_clk_out) && !st.fresh && !$past(st.fresh)) |->
		(cept ? ($past(st.per) >= CEPT_PER_MIN && $past(st.per) <= CEPT_PER_MAX)
		      : ($past(st.per) >= DS1_PER_MIN && $past(st.per) <= DS1_PER_MAX)))
		else $error("transmit line clock period out of range");
	a_rx_out_timing: assert property (
		$changed(o_rx_frame_sync_out) |-> $rose(o_rx_framer_clk_out))
		else $error("frame sync moved off the framer clock rise");
	a_data_forced: assert property (
		o_rx_align_lost |-> o_rx_decoded_data_out)
		else $error("receive data not forced high during loss");
	// the pulse is one framer bit wide, so it must drop at the next framer clock rise
	a_fs_once: assert property (
		($rose(o_rx_framer_clk_out) && $past(o_rx_frame_sync_out)) |-> !o_rx_frame_sync_out)
		else $error("frame sync wider than one bit");
	a_mf_in_cept: assert property (
		o_rx_sig_multiframe_sync |-> (cept && o_rx_frame_sync_out))
		else $error("signaling multiframe pulse outside a CEPT frame start");
	a_crc_in_cept: assert property (
		o_rx_crc_multiframe_sync |-> (cept && o_rx_frame_sync_out))
		else $error("CRC multiframe pulse outside a CEPT frame start");
	a_dl_on_fall: assert property (
		($changed(o_rx_datalink_out) && !o_rx_align_lost) |-> $fell(o_rx_datalink_clk))
		else $error("data link bit changed off the clock fall");
	a_dl_forced: assert property (
		o_rx_align_lost |-> o_rx_datalink_out)
		else $error("data link not held high during loss");
	a_master_sync: assert property (
		$rose(o_tx_highway_frame_sync_out) |-> (o_tx_highway_frame_sync_oe && $past(s_hclk)))
		else $error("highway sync rose while not master");
	a_bpv_count: assert property (
		(st.bpv != $past(st.bpv)) |-> ($past(rx_rise) && $past(single) && $past(s_rneg)))
		else $error("violation count moved without a negative rail mark");

	c_realign:    cover property ($fell(o_rx_align_lost));
	c_sig_mf:     cover property (o_rx_sig_multiframe_sync);
	c_dl_edge:    cover property ($fell(o_rx_datalink_clk) && !o_rx_align_lost);
	c_master_fs:  cover property ($rose(o_tx_highway_frame_sync_out));
endmodule : flp_top

// file: sim/flp_far_end.sv
// flp_far_end: line unit and highway timing logic facing the framer pins
// assumes the bench sets run, align and violation controls
`timescale 1ns/1ps
module flp_far_end (
	input  wire logic i_run,
	input  wire logic i_align,
	input  wire logic i_viol,
	output logic      o_rx_clk,
	output logic      o_rx_pos,
	output logic      o_rx_neg,
	output logic      o_hw_clk,
	output logic      o_hw_fs
);
	localparam logic [6:0] ALIGN_WORD = 7'h1B;
	int bit_n = 0;
	int hw_n  = 0;
	initial begin
		{o_rx_clk, o_rx_pos, o_rx_neg, o_hw_clk, o_hw_fs} = 5'h00;
		#7;
		forever begin
			#80;
			if (!i_run) begin
				// clock stands still; idle rails never repeat a level
				o_rx_clk = 1'b0;
				o_rx_pos = ~o_rx_pos;
				o_rx_neg = ~o_rx_neg;
			end else if (o_rx_clk) begin
				o_rx_clk = 1'b0;
				o_rx_neg = i_viol;
				// zeros while misaligned can never form the word
				o_rx_pos = i_align && (bit_n < 1 || bit_n > 7 || ALIGN_WORD[7 - bit_n]);
				bit_n    = (bit_n + 1) % 256;
			end else begin
				o_rx_clk = 1'b1;
			end
		end
	end
	initial begin
		#3;
		forever #244 o_hw_clk = ~o_hw_clk;
	end
	always @(posedge o_hw_clk) begin
		o_hw_fs <= (hw_n == 0);
		hw_n    <= (hw_n + 1) % 256;
	end
endmodule : flp_far_end

// file: sim/flp_top_tb.sv
// flp_top_tb: self-checking bench for the framer line and highway pins
// assumes flp_far_end on the line and highway pins; straps driven here
`timescale 1ns/1ps
module flp_top_tb;
	import flp_pkg::*;
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic        hsel   = 1'b0;
	logic [31:0] haddr  = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        tx_pos = 1'b0;
	logic        tx_neg = 1'b1;
	logic        byp    = 1'b0;
	logic        sel16  = 1'b1;
	logic        run    = 1'b0;
	logic        align  = 1'b1;
	logic        viol   = 1'b0;
	logic        mon_on = 1'b0;
	logic        single = 1'b0;
	logic        p_in, p_tx_line_clk_out, p_tpos, p_tneg, p_dl, p_dlck, p_lost;
	int          n_mismatch = 0;
	int          cmp_count  = 0;
	wire logic [31:0] hrdata;
	wire logic        hready, hresp, take, tpos, tneg, tx_line_clk_out, rfck, rdata, rx_frame_sync_out, rsig, rcrc;
	wire logic        dlck, dl, lost, hwfs, hwoe, rxc, rxp, rxn, hwc, hwi;
	wire logic [4:0]  mult;
	wire logic [9:0]  mon = {~rdata, lost, ~lost, ~dl, rsig, hwfs, rx_frame_sync_out, dlck, tx_line_clk_out, rfck};

	initial forever #10 clk = ~clk;

	flp_top i_dut (
		.i_core_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_tx_pos_data(tx_pos), .i_tx_neg_data(tx_neg), .o_tx_data_take(take),
		.o_tx_pos_rail_out(tpos), .o_tx_neg_rail_out(tneg), .o_tx_line_clk_out(tx_line_clk_out),
		.i_rx_line_clk_in(rxc), .i_rx_pos_rail_in(rxp), .i_rx_neg_rail_in(rxn),
		.i_line_bypass_strap(byp), .i_sysclk_rate_select(sel16),
		.o_line_unit_sysclk_mult(mult), .o_rx_framer_clk_out(rfck),
		.o_rx_decoded_data_out(rdata), .o_rx_frame_sync_out(rx_frame_sync_out),
		.o_rx_sig_multiframe_sync(rsig), .o_rx_crc_multiframe_sync(rcrc),
		.o_rx_datalink_clk(dlck), .o_rx_datalink_out(dl), .o_rx_align_lost(lost),
		.i_tx_highway_clk(hwc), .i_tx_highway_frame_sync_in(hwi),
		.o_tx_highway_frame_sync_out(hwfs), .o_tx_highway_frame_sync_oe(hwoe));

	flp_far_end i_far (.i_run(run), .i_align(align), .i_viol(viol), .o_rx_clk(rxc),
		.o_rx_pos(rxp), .o_rx_neg(rxn), .o_hw_clk(hwc), .o_hw_fs(hwi));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_in(input string what, input int lo, input int hi, input int got);
		cmp_count++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("Error %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
		end
	endtask : chk_in

	// watches the rails and link bit on every core clock rise
	always @(posedge clk) begin
		if (mon_on && {tpos, tneg} !== {p_tpos, p_tneg})
			chk("rail change", 1, tx_line_clk_out & ~p_tx_line_clk_out);
		if (mon_on && take)
			chk("pos rail", p_in, tpos);
		if (mon_on && single)
			chk("neg rail", 0, tneg);
		if (!lost && !p_lost && dl !== p_dl)
			chk("link change", 1, p_dlck & ~dlck);
		if (take)
			tx_pos <= ~tx_pos;
		{p_in, p_tx_line_clk_out, p_tpos, p_tneg} <= {tx_pos, tx_line_clk_out, tpos, tneg};
		{p_dl, p_dlck, p_lost} <= {dl, dlck, lost};
	end

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic count_rises(input int idx, input int ncyc, output int n);
		logic p;
		n = 0;
		p = mon[idx];
		repeat (ncyc) begin
			@(posedge clk);
			n += int'(mon[idx] === 1'b1 && p === 1'b0);
			p = mon[idx];
		end
	endtask : count_rises

	task automatic wait_rise(input int idx, output int c);
		logic p;
		c = 0;
		p = 1'b1;
		while (!(mon[idx] === 1'b1 && p === 1'b0) && c < 40000) begin
			p = mon[idx];
			@(posedge clk);
			c++;
		end
		if (c >= 40000) begin
			n_mismatch++;
			$display("Error rise on monitor %0d: expected within 40000 cycles, seen none", idx);
			tally_and_finish();
		end
	endtask : wait_rise

	task automatic rise_gap(input int idx, output int g);
		int c;
		wait_rise(idx, c);
		wait_rise(idx, g);
	endtask : rise_gap

	task automatic t_regs;
		logic [31:0] d;
		bus(1, CTRL_OFF, 32'hFFFF_FFFF, d);
		bus(0, CTRL_OFF, 32'h0, d);
		chk("ctrl", CTRL_MASK, d);
		bus(1, CTRL_OFF, 32'h0, d);
		bus(1, 32'h0000_0010, 32'hFFFF_FFFF, d);
		bus(0, 32'h0000_0010, 32'h0, d);
		chk("unmapped", 32'h0, d);
		bus(0, STATUS_OFF, 32'h0, d);
		chk("status", 32'h5, {29'h0, d[2:0]});
		chk("hresp", 0, hresp);
		chk("mult hi", SYSCLK_MULT_HI, mult);
		sel16 <= 1'b0;
		repeat (8) @(posedge clk);
		chk("mult lo", SYSCLK_MULT_LO, mult);
	endtask : t_regs

	task automatic t_tx;
		logic [31:0] d;
		int n;
		mon_on <= 1'b1;
		count_rises(1, 3000, n);
		chk_in("ds1 line clk", 91, 95, n);
		bus(1, CTRL_OFF, 32'h2, d);
		count_rises(1, 3000, n);
		chk_in("cept line clk", 121, 125, n);
		chk("dual neg rail", 1, tneg);
		mon_on <= 1'b0;
		bus(1, CTRL_OFF, 32'h3, d);
		repeat (2) @(posedge clk);
		mon_on <= 1'b1;
		single <= 1'b1;
		repeat (500) @(posedge clk);
		mon_on <= 1'b0;
	endtask : t_tx

	task automatic t_rx;
		logic [31:0] d, e;
		int n;
		bus(1, CTRL_OFF, 32'h2, d);
		run <= 1'b1;
		// the word arrives in the first frame, so watch for it before anything else
		wait_rise(7, n);
		chk_in("align time", 8, 2048, n);
		chk("aligned", 0, lost);
		count_rises(0, 800, n);
		chk_in("rx framer clk", 98, 102, n);
		count_rises(9, 2048, n);
		chk_in("rx data zeros", 1, 4, n);
		rise_gap(3, n);
		chk_in("frame sync gap", 2045, 2051, n);
		rise_gap(2, n);
		chk_in("link clk gap", 4093, 4099, n);
		count_rises(6, 4096, n);
		chk_in("sa4 link", 0, 0, n);
		bus(1, CTRL_OFF, 32'h22, d);
		count_rises(6, 4096, n);
		chk_in("sa6 link", 1, 2, n);
		wait_rise(5, n);
		chk("frame sync at mf", 1, rx_frame_sync_out);
		chk("crc mf", 1, rcrc);
		bus(1, CTRL_OFF, 32'h3, d);
		viol <= 1'b1;
		bus(0, STATUS_OFF, 32'h0, d);
		repeat (800) @(posedge clk);
		bus(0, STATUS_OFF, 32'h0, e);
		chk_in("violations", 98, 103, int'(e[31:16] - d[31:16]));
		bus(1, CTRL_OFF, 32'h2, d);
		viol  <= 1'b0;
		align <= 1'b0;
		wait_rise(8, n);
		count_rises(9, 4096, n);
		chk_in("rx data at loss", 0, 0, n);
		chk("link at loss", 1, dl);
		chk("loss flag", 1, lost);
	endtask : t_rx

	task automatic t_hw;
		logic [31:0] d;
		int n;
		bus(1, CTRL_OFF, 32'hC, d);
		repeat (2) @(posedge clk);
		chk("sync oe", 1, hwoe);
		rise_gap(4, n);
		chk_in("sync gap", 6240, 6253, n);
		// DDS link access in ds1 gives one link clock per 193-bit frame
		rise_gap(2, n);
		chk_in("dds link clk gap", 1541, 1547, n);
		bus(1, CTRL_OFF, 32'h0, d);
		repeat (2) @(posedge clk);
		chk("sync oe off", 0, hwoe);
		byp <= 1'b1;
		repeat (8) @(posedge clk);
		count_rises(0, 800, n);
		chk_in("rx clk strapped", 0, 0, n);
		chk("tx rail idle", 0, tpos);
	endtask : t_hw

	task automatic tally_and_finish;
		$display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// scenarios need about 65,000 cycles; the margin covers about a dozen missed frames
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_tx();
		t_rx();
		t_hw();
		tally_and_finish();
	end
endmodule : flp_top_tb
